/* File: tb/core_model.sv */
/*
 core and development port stand-in: issues one load/store access with its
 watchpoint events and interrupt pulses, and holds the port trap enables.
 assumes requests arrive by non-blocking assignment just after a rising edge.
*/
module core_model (
    input  wire logic        clk_in,                // core clock
    input  wire logic        fire_in,               // issue one access next cycle
    input  wire logic [37:0] ev_in,                 // {insn[3:0], e, f, data}
    input  wire logic [6:0]  irq_in,                // {mc, ext, mis, prog, fp, dec, sys}
    input  wire logic [1:0]  trap_en_in,            // port trap enables wanted
    output logic             ls_valid_out = 1'b0,   // access this cycle
    output logic [31:0]      ls_data_out = 32'h0,   // access data
    output logic             e_hit_out = 1'b0,      // comparator E event
    output logic             f_hit_out = 1'b0,      // comparator F event
    output logic [3:0]       insn_out = 4'h0,       // instruction watch events
    output logic [6:0]       irq_out = 7'h00,       // interrupt pulses
    output logic [1:0]       trap_en_out = 2'h0     // port trap enables
);
    timeunit 1ns;
    timeprecision 1ps;
    // data bus toggles when idle so a stale value never looks valid
    always @(posedge clk_in) begin
        ls_valid_out <= fire_in;
        insn_out <= fire_in ? ev_in[37:34] : 4'h0;
        e_hit_out <= fire_in & ev_in[33];
        f_hit_out <= fire_in & ev_in[32];
        ls_data_out <= fire_in ? ev_in[31:0] : ~ls_data_out;
        irq_out <= fire_in ? irq_in : 7'h00;
        trap_en_out <= trap_en_in;
    end
endmodule

/* File: tb/lsw_debug_bench.sv */
/*
 self-checking bench of the load/store watch block: counters, then table of watchpoint cases,
 then cause register, machine check and a second reset.
 assumes an apb slave answering in two access cycles.
*/
module lsw_debug_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] cmp;
        logic [31:0] wc;
        logic [5:0]  ev;
        logic [31:0] d;
        logic [1:0]  rh;
    } row_t;
    localparam logic [31:0] CE = 32'h02400000;
    localparam logic [31:0] DV = 32'hA5A5A500;
    localparam row_t ROWS [25] = '{
        '{CE, 32'h00000000, 6'h00, DV, 2'h2},
        '{CE, 32'h80000002, 6'h00, DV, 2'h3},
        '{CE, 32'h80000000, 6'h00, DV, 2'h0},
        '{CE, 32'h80000800, 6'h00, DV, 2'h1},
        '{CE, 32'h90000000, 6'h04, DV, 2'h3},
        '{CE, 32'hB0000000, 6'h04, DV, 2'h2},
        '{CE, 32'hD0000000, 6'h10, DV, 2'h3},
        '{CE, 32'hF0000000, 6'h2C, DV, 2'h3},
        '{CE, 32'h82000000, 6'h02, DV, 2'h3},
        '{CE, 32'h86000000, 6'h02, DV, 2'h2},
        '{CE, 32'h8A000000, 6'h02, DV, 2'h2},
        '{CE, 32'h8A000000, 6'h03, DV, 2'h3},
        '{CE, 32'h8E000000, 6'h01, DV, 2'h3},
        '{CE, 32'h80400000, 6'h00, DV, 2'h3},
        '{CE, 32'h80C00000, 6'h00, DV, 2'h2},
        '{CE, 32'h81400000, 6'h00, DV, 2'h2},
        '{CE, 32'h81C00000, 6'h00, DV, 2'h3},
        '{CE, 32'h92400000, 6'h06, DV, 2'h3},
        '{CE, 32'h92400000, 6'h06, 32'hA5A5A501, 2'h2},
        '{CE, 32'h92400000, 6'h04, DV, 2'h2},
        '{32'h02400040, 32'h80400000, 6'h00, 32'hA5A5A5FF, 2'h3},
        '{CE, 32'h80400000, 6'h00, 32'hA5A5A5FF, 2'h2},
        '{32'h0240003C, 32'h80C00000, 6'h00, 32'h12345678, 2'h3},
        '{32'h02C00000, 32'h80400000, 6'h00, 32'h00000000, 2'h2},
        '{32'h02C00800, 32'h80400000, 6'h00, 32'h00000000, 2'h3}
    };
    logic        clk_sys_in = 1'b0, sys_rst_in = 1'b1, fire = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, cause_enable_in = 32'h0, rd;
    logic        recoverable_in = 1'b0, mcheck_enable_in = 1'b0, debug_enable_in = 1'b0, er;
    logic [37:0] ev = 38'h0;
    logic [6:0]  irq = 7'h00, irq_w;
    logic [1:0]  pt = 2'h0, port_trap_in, watch_hit_out, soft_trap_out;
    logic [1:0]  port_trap_out, count_break_out;
    logic [31:0] prdata_out, ls_data_in;
    logic        pready_out, pslverr_out, ls_valid_in, cmp_e_hit_in, cmp_f_hit_in;
    logic        debug_entry_out, checkstop_out;
    logic [3:0]  insn_watch_in;
    int          failures = 0, checks = 0;
    int          cb [6] = '{25, 24, 23, 22, 21, 18};

    lsw_debug uut (.clk_sys_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ls_valid_in, .ls_data_in,
        .cmp_g_value_in(DV), .cmp_h_value_in(32'h0F0F0F0F), .cmp_e_hit_in, .cmp_f_hit_in,
        .insn_watch_in, .recoverable_in, .mcheck_enable_in, .port_trap_in,
        .machine_check_in(irq_w[6]), .ext_irq_in(irq_w[5]), .misaligned_in(irq_w[4]),
        .program_in(irq_w[3]),
        .float_unavail_in(irq_w[2]), .decrementer_in(irq_w[1]), .syscall_in(irq_w[0]),
        .debug_enable_in, .cause_enable_in, .watch_hit_out, .soft_trap_out, .port_trap_out,
        .count_break_out, .debug_entry_out, .checkstop_out);
    core_model core (.clk_in(clk_sys_in), .fire_in(fire), .ev_in(ev), .irq_in(irq),
        .trap_en_in(pt), .ls_valid_out(ls_valid_in), .ls_data_out(ls_data_in),
        .e_hit_out(cmp_e_hit_in), .f_hit_out(cmp_f_hit_in), .insn_out(insn_watch_in),
        .irq_out(irq_w), .trap_en_out(port_trap_in));

    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        // no cycle limit here: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk_sys_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // outputs launched at the third edge are read at the edge after it
    task go(input logic [5:0] e, input logic [31:0] d, input logic [6:0] q);
        @(posedge clk_sys_in);
        fire <= 1'b1;
        ev <= {e, d};
        irq <= q;
        @(posedge clk_sys_in);
        fire <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        pt <= 2'h1;
        apb(0, 8'h10, 0);
        chk("cause", 32'h40000000, rd);
        apb(1, 8'h04, 32'hFFFFF80F);
        apb(0, 8'h04, 0);
        chk("watch_ctl", 32'hFFFFF80B, rd);
        apb(1, 8'h08, 32'h00030001);
        apb(0, 8'h08, 0);
        chk("count_a", 32'h00030001, rd);
        apb(1, 8'h0C, 32'h00020001);
        for (int k = 1; k <= 3; k++) begin
            go(6'h0C, DV, 7'h00);
            chk("count_break", {30'h0, k == 2, k == 3}, {30'h0, count_break_out});
        end
        apb(0, 8'h14, 0);
        chk("count_now", 32'h00010003, rd);
        foreach (ROWS[i]) begin
            apb(1, 8'h00, ROWS[i].cmp);
            apb(1, 8'h04, ROWS[i].wc);
            recoverable_in <= ROWS[i].rh[1];
            go(ROWS[i].ev, ROWS[i].d, 7'h00);
            chk("watch_hit", {31'h0, ROWS[i].rh[0]}, {30'h0, watch_hit_out});
            chk("soft_trap", {31'h0, ROWS[i].rh[0] & ROWS[i].wc[1]}, {30'h0, soft_trap_out});
            chk("port_trap", {31'h0, ROWS[i].rh[0]}, {30'h0, port_trap_out});
        end
        apb(1, 8'h08, 32'h00010002);
        go(6'h00, 32'h00000000, 7'h00);
        chk("count_break", 32'h1, {30'h0, count_break_out});
        pt <= 2'h3;
        apb(1, 8'h04, 32'h00200001);
        go(6'h00, 32'h00000000, 7'h00);
        chk("watch1_hit", 32'h2, {30'h0, watch_hit_out});
        chk("soft_trap", 32'h2, {30'h0, soft_trap_out});
        chk("port_trap", 32'h2, {30'h0, port_trap_out});
        debug_enable_in <= 1'b1;
        apb(1, 8'h10, 32'h73E40000);
        for (int j = 0; j < 6; j++) begin
            cause_enable_in <= (j % 2 == 0) ? 32'hFFFFFFFF : 32'h0;
            go(6'h00, DV, 7'h01 << (5 - j));
            chk("debug_entry", {31'h0, j % 2 == 0}, {31'h0, debug_entry_out});
            apb(0, 8'h10, 0);
            chk("cause", 32'h1 << cb[j], rd);
        end
        mcheck_enable_in <= 1'b1;
        cause_enable_in <= 32'h10000000;
        go(6'h00, DV, 7'h40);
        chk("debug_entry", 32'h1, {31'h0, debug_entry_out});
        apb(0, 8'h10, 0);
        chk("cause", 32'h10000000, rd);
        mcheck_enable_in <= 1'b0;
        cause_enable_in <= 32'h0;
        go(6'h00, DV, 7'h40);
        chk("checkstop", 32'h1, {31'h0, checkstop_out});
        apb(0, 8'h10, 0);
        chk("cause", 32'h20000000, rd);
        pt <= 2'h0;
        sys_rst_in <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        apb(0, 8'h10, 0);
        chk("cause", 32'h40000000, rd);
        chk("checkstop", 32'h0, {31'h0, checkstop_out});
        apb(0, 8'h04, 0);
        chk("watch_ctl", 32'h0, rd);
        apb(0, 8'h08, 0);
        chk("count_a_ctl", 32'h0, rd & 32'h0000FFFF);
        apb(0, 8'h18, 0);
        chk("unmapped", 32'h1, {31'h0, er});
        wrap_up;
    end
endmodule

/* File: verilog/data_cmp.sv */
/*
 one load data comparator with signed/unsigned mode and per-byte mask.
 assumes data and reference are stable in the cycle they are compared.
*/
module data_cmp #(
    parameter int W = 32
) (
    input  wire logic [W-1:0]   data_in,      // load/store data
    input  wire logic [W-1:0]   ref_in,       // comparator value
    input  wire logic [2:0]     type_in,      // compare type, msb 0 inactive
    input  wire logic           unsigned_in,  // 1 unsigned, 0 signed
    input  wire logic [W/8-1:0] mask_in,      // lsb masks the last byte
    output logic                hit_out       // compare met
);
    logic [W-1:0] dm;
    logic [W-1:0] rm;
    logic         lt;
    logic         eq;

    genvar b;
    generate
        for (b = 0; b < W/8; b++) begin : g_lane
            // masked lanes take part as equal zeros
            assign dm[b*8 +: 8] = mask_in[b] ? 8'h00 : data_in[b*8 +: 8];
            assign rm[b*8 +: 8] = mask_in[b] ? 8'h00 : ref_in[b*8 +: 8];
        end
    endgenerate

    assign eq = (dm == rm);
    assign lt = unsigned_in ? (dm < rm) : ($signed(dm) < $signed(rm));

    always_comb begin
        case (type_in)
            lsw_pkg::CMP_EQ: hit_out = eq;
            lsw_pkg::CMP_LT: hit_out = lt;
            lsw_pkg::CMP_GT: hit_out = ~lt & ~eq;
            lsw_pkg::CMP_NE: hit_out = ~eq;
            default:         hit_out = 1'b0;
        endcase
    end
endmodule

/* File: verilog/lsw_debug.sv */
/*
 load/store watchpoints, breakpoint counters and debug entry cause register,
 reached over an apb slave.
 assumes core event inputs are one-cycle pulses synchronous to clk_sys_in.
*/
`include "lsw_defs.svh"
module lsw_debug #(
    parameter int CNT_W = 16
) (
    input  wire logic        clk_sys_in,       // core clock
    input  wire logic        sys_rst_in,       // sync reset, high
    input  wire logic        psel_in,          // apb select
    input  wire logic        penable_in,       // apb enable
    input  wire logic        pwrite_in,        // apb direction
    input  wire logic [7:0]  paddr_in,         // apb byte address
    input  wire logic [31:0] pwdata_in,        // apb write data
    output logic [31:0]      prdata_out,       // apb read data
    output logic             pready_out,       // apb ready
    output logic             pslverr_out,      // apb error, unmapped
    input  wire logic        ls_valid_in,      // load/store access this cycle
    input  wire logic [31:0] ls_data_in,       // load/store data
    input  wire logic [31:0] cmp_g_value_in,   // comparator G value
    input  wire logic [31:0] cmp_h_value_in,   // comparator H value
    input  wire logic        cmp_e_hit_in,     // address comparator E
    input  wire logic        cmp_f_hit_in,     // address comparator F
    input  wire logic [3:0]  insn_watch_in,    // instruction watchpoints
    input  wire logic        recoverable_in,   // recoverable state bit
    input  wire logic        mcheck_enable_in, // machine check enable bit
    input  wire logic [1:0]  port_trap_in,     // trap enables from dev port
    input  wire logic        machine_check_in, // machine check request
    input  wire logic        ext_irq_in,       // external interrupt
    input  wire logic        misaligned_in,    // alignment interrupt
    input  wire logic        program_in,       // program interrupt
    input  wire logic        float_unavail_in, // fp unavailable interrupt
    input  wire logic        decrementer_in,   // decrementer interrupt
    input  wire logic        syscall_in,       // system call interrupt
    input  wire logic        debug_enable_in,  // debug mode enabled
    input  wire logic [31:0] cause_enable_in,  // per-cause entry enables
    output logic [1:0]       watch_hit_out,    // recognised watchpoint
    output logic [1:0]       soft_trap_out,    // software trap request
    output logic [1:0]       port_trap_out,    // dev port trap request
    output logic [1:0]       count_break_out,  // counter terminal break
    output logic             debug_entry_out,  // enter debug mode
    output logic             checkstop_out     // check stop state
);
    logic [31:0]      cmp_ctl_ff;
    logic [31:0]      watch_ctl_ff;
    logic [31:0]      cause_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic             rst_seen_ff;
    logic [1:0]       hit_ff;
    logic [1:0]       soft_ff;
    logic [1:0]       port_ff;
    logic             brk_ff [2];
    logic             entry_ff;
    logic             stop_ff;
    logic [1:0]       port_en_ff;
    logic [CNT_W-1:0] preset_ff [2];
    logic [1:0]       src_ff [2];
    logic [CNT_W-1:0] count_ff [2];

    logic [5:0]  idx;
    logic        mapped;
    logic        acc_start;
    logic        acc_done;
    logic        wr_done;
    logic        rd_done;
    logic        g_hit;
    logic        h_hit;
    logic        brk_ok;
    logic [1:0]  nxt_hit;
    logic [31:0] nxt_set;
    logic [31:0] rdata;
    logic [31:0] clr_mask;

    assign idx       = paddr_in[7:2];
    assign mapped    = (idx <= `LSW_OFS_COUNT_NOW);
    assign acc_start = psel_in & penable_in & ~pready_ff;
    assign acc_done  = psel_in & penable_in & pready_ff;
    assign wr_done   = acc_done & pwrite_in & mapped;
    assign rd_done   = acc_done & ~pwrite_in;

    data_cmp #(.W(32)) u_cmp_g (
        .data_in     (ls_data_in),
        .ref_in      (cmp_g_value_in),
        .type_in     (cmp_ctl_ff[`LSW_CMP_G_TYPE -: 3]),
        .unsigned_in (cmp_ctl_ff[`LSW_CMP_G_SIGN]),
        .mask_in     (cmp_ctl_ff[`LSW_CMP_G_MASK -: 4]),
        .hit_out     (g_hit)
    );

    data_cmp #(.W(32)) u_cmp_h (
        .data_in     (ls_data_in),
        .ref_in      (cmp_h_value_in),
        .type_in     (cmp_ctl_ff[`LSW_CMP_H_TYPE -: 3]),
        .unsigned_in (cmp_ctl_ff[`LSW_CMP_H_SIGN]),
        .mask_in     (cmp_ctl_ff[`LSW_CMP_H_MASK -: 4]),
        .hit_out     (h_hit)
    );

    // apb: one wait state, answer captured at the first access edge
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= acc_start;
            pslverr_ff <= acc_start & ~mapped;
            if (acc_start) begin
                prdata_ff <= pwrite_in ? 32'h00000000 : rdata;
            end
        end
    end

    always_comb begin
        case (idx)
            `LSW_OFS_CMP_CTL:   rdata = cmp_ctl_ff;
            `LSW_OFS_WATCH_CTL: rdata = watch_ctl_ff;
            `LSW_OFS_COUNT_A:   rdata = {preset_ff[0], 14'h0000, src_ff[0]};
            `LSW_OFS_COUNT_B:   rdata = {preset_ff[1], 14'h0000, src_ff[1]};
            `LSW_OFS_CAUSE:     rdata = cause_ff;
            `LSW_OFS_COUNT_NOW: rdata = {count_ff[1], count_ff[0]};
            default:            rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cmp_ctl_ff <= 32'h00000000;
        end else if (wr_done && idx == `LSW_OFS_CMP_CTL) begin
            cmp_ctl_ff <= pwdata_in & `LSW_CMP_CTL_WMASK;
        end
    end

    // port trap enables belong to the development port, never to software
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            port_en_ff <= 2'h0;
        end else begin
            port_en_ff <= port_trap_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            watch_ctl_ff <= `LSW_WATCH_RESET;
        end else begin
            if (wr_done && idx == `LSW_OFS_WATCH_CTL) begin
                // reserved bits are dropped whatever software sends
                watch_ctl_ff <= pwdata_in & `LSW_WATCH_WMASK;
            end
            watch_ctl_ff[`LSW_PORT_TRAP0]   <= port_en_ff[0];
            watch_ctl_ff[`LSW_PORT_TRAP0-1] <= port_en_ff[1];
        end
    end

    assign brk_ok = watch_ctl_ff[`LSW_BRK_UNMASKED] | recoverable_in;

    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : g_watch
            localparam int B = `LSW_WATCH_BASE - w * `LSW_WATCH_STRIDE;
            logic [1:0] ia;
            logic [1:0] la;
            logic [1:0] ld;
            logic       ev_i;
            logic       ev_a;
            logic       ev_d;
            assign ia = watch_ctl_ff[B-1 -: 2];
            assign la = watch_ctl_ff[B-4 -: 2];
            assign ld = watch_ctl_ff[B-7 -: 2];
            assign ev_i = insn_watch_in[ia];
            always_comb begin
                case (la)
                    lsw_pkg::PICK_FIRST:  ev_a = cmp_e_hit_in;
                    lsw_pkg::PICK_SECOND: ev_a = cmp_f_hit_in;
                    lsw_pkg::PICK_AND:    ev_a = cmp_e_hit_in & cmp_f_hit_in;
                    default:              ev_a = cmp_e_hit_in | cmp_f_hit_in;
                endcase
                case (ld)
                    lsw_pkg::PICK_FIRST:  ev_d = g_hit;
                    lsw_pkg::PICK_SECOND: ev_d = h_hit;
                    lsw_pkg::PICK_AND:    ev_d = g_hit & h_hit;
                    default:              ev_d = g_hit | h_hit;
                endcase
            end
            assign nxt_hit[w] = watch_ctl_ff[B] & ls_valid_in & brk_ok
                              & (~watch_ctl_ff[B-3] | ev_i)
                              & (~watch_ctl_ff[B-6] | ev_a)
                              & (~watch_ctl_ff[B-9] | ev_d);
        end
    endgenerate

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            hit_ff  <= 2'h0;
            soft_ff <= 2'h0;
            port_ff <= 2'h0;
        end else begin
            hit_ff     <= nxt_hit;
            soft_ff[0] <= nxt_hit[0] & watch_ctl_ff[`LSW_SOFT_TRAP0];
            soft_ff[1] <= nxt_hit[1] & watch_ctl_ff[`LSW_SOFT_TRAP0-1];
            port_ff[0] <= nxt_hit[0] & watch_ctl_ff[`LSW_PORT_TRAP0];
            port_ff[1] <= nxt_hit[1] & watch_ctl_ff[`LSW_PORT_TRAP0-1];
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_cnt
            logic ev;
            logic wr;
            assign wr = wr_done && idx == (`LSW_OFS_COUNT_A + 6'(c));
            always_comb begin
                case (src_ff[c])
                    lsw_pkg::SRC_INSN: ev = insn_watch_in[c];
                    lsw_pkg::SRC_LS:   ev = nxt_hit[c];
                    default:           ev = 1'b0;
                endcase
            end
            // preset has no reset value; only the control half is cleared
            always_ff @(posedge clk_sys_in) begin
                if (wr) begin
                    preset_ff[c] <= pwdata_in[`LSW_CNT_PRESET_MSB -: CNT_W];
                end
            end
            always_ff @(posedge clk_sys_in) begin
                if (sys_rst_in) begin
                    src_ff[c] <= 2'h0;
                end else if (wr) begin
                    src_ff[c] <= pwdata_in[`LSW_CNT_SRC_MSB -: 2];
                end
            end
            always_ff @(posedge clk_sys_in) begin
                if (sys_rst_in) begin
                    count_ff[c] <= '0;
                    brk_ff[c]   <= 1'b0;
                end else if (wr) begin
                    count_ff[c] <= pwdata_in[`LSW_CNT_PRESET_MSB -: CNT_W];
                    brk_ff[c]   <= 1'b0;
                end else begin
                    brk_ff[c] <= ev && count_ff[c] == CNT_W'(1);
                    if (ev && count_ff[c] == CNT_W'(1)) begin
                        count_ff[c] <= preset_ff[c];
                    end else if (ev && count_ff[c] != '0) begin
                        count_ff[c] <= count_ff[c] - CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_set = 32'h00000000;
        nxt_set[`LSW_CAUSE_RST]       = rst_seen_ff;
        nxt_set[`LSW_CAUSE_CHECKSTOP] = machine_check_in & ~mcheck_enable_in;
        nxt_set[`LSW_CAUSE_MCHECK]    = machine_check_in & mcheck_enable_in;
        nxt_set[`LSW_CAUSE_EXT]       = ext_irq_in;
        nxt_set[`LSW_CAUSE_ALIGN]     = misaligned_in;
        nxt_set[`LSW_CAUSE_PROG]      = program_in;
        nxt_set[`LSW_CAUSE_FPU]       = float_unavail_in;
        nxt_set[`LSW_CAUSE_DEC]       = decrementer_in;
        nxt_set[`LSW_CAUSE_SYSCALL]   = syscall_in;
    end

    // only bits already returned to the reader are cleared
    assign clr_mask = (rd_done && idx == `LSW_OFS_CAUSE) ? prdata_ff : 32'h00000000;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rst_seen_ff <= 1'b1;
            cause_ff    <= `LSW_CAUSE_RESET;
        end else begin
            rst_seen_ff <= 1'b0;
            cause_ff    <= (cause_ff & ~clr_mask) | nxt_set;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            entry_ff <= 1'b0;
            stop_ff  <= 1'b0;
        end else begin
            entry_ff <= debug_enable_in & |(nxt_set & cause_enable_in);
            if (nxt_set[`LSW_CAUSE_CHECKSTOP] &&
                !(debug_enable_in && cause_enable_in[`LSW_CAUSE_CHECKSTOP])) begin
                stop_ff <= 1'b1;
            end
        end
    end

    assign prdata_out      = prdata_ff;
    assign pready_out      = pready_ff;
    assign pslverr_out     = pslverr_ff;
    assign watch_hit_out   = hit_ff;
    assign soft_trap_out   = soft_ff;
    assign port_trap_out   = port_ff;
    assign count_break_out = {brk_ff[1], brk_ff[0]};
    assign debug_entry_out = entry_ff;
    assign checkstop_out   = stop_ff;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_access;
        psel_in && penable_in && !pready_ff;
    endsequence

    sequence s_cause_read;
        rd_done && idx == `LSW_OFS_CAUSE;
    endsequence

    AST_APB_ONE_WAIT: assert property (s_access |=> pready_out)
        else $error("apb ready not one cycle after access start");
    AST_WATCH_NEEDS_EN: assert property (
        !watch_ctl_ff[`LSW_WATCH_BASE] && !watch_ctl_ff[`LSW_WATCH_BASE-10]
        |=> watch_hit_out == 2'h0)
        else $error("watchpoint hit while disabled");
    AST_MASKED_NEEDS_RI: assert property (
        !watch_ctl_ff[`LSW_BRK_UNMASKED] && !recoverable_in |=> watch_hit_out == 2'h0)
        else $error("masked breakpoint recognised without ri");
    AST_SOFT_TRAP: assert property (
        soft_trap_out[0] |-> watch_hit_out[0] && $past(watch_ctl_ff[`LSW_SOFT_TRAP0]))
        else $error("soft trap without enabled hit");
    AST_CHECKSTOP: assert property (
        machine_check_in && !mcheck_enable_in |=> cause_ff[`LSW_CAUSE_CHECKSTOP]
        && (checkstop_out || $past(debug_enable_in)))
        else $error("checkstop not recorded");
    AST_MCHECK_CAUSE: assert property (
        machine_check_in && mcheck_enable_in |=> cause_ff[`LSW_CAUSE_MCHECK])
        else $error("machine check cause not set");
    AST_CLEAR_ON_READ: assert property (
        s_cause_read ##0 (!ext_irq_in && prdata_ff[`LSW_CAUSE_EXT])
        |=> !cause_ff[`LSW_CAUSE_EXT])
        else $error("cause bit not cleared by read");
    AST_ENTRY_GATED: assert property (debug_entry_out |-> $past(debug_enable_in))
        else $error("debug entry without debug enable");
    AST_COUNT_BREAK: assert property (
        count_break_out[0] |-> count_ff[0] == preset_ff[0])
        else $error("counter not reloaded at terminal");
endmodule

/* File: verilog/lsw_defs.svh */
/*
 offsets, field positions, reset values and write masks of the load/store watch block.
 assumes bit 0 of every field list is the word msb; positions below are vector indices.
*/
`ifndef LSW_DEFS_SVH
`define LSW_DEFS_SVH

`define LSW_OFS_CMP_CTL    6'h00
`define LSW_OFS_WATCH_CTL  6'h01
`define LSW_OFS_COUNT_A    6'h02
`define LSW_OFS_COUNT_B    6'h03
`define LSW_OFS_CAUSE      6'h04
`define LSW_OFS_COUNT_NOW  6'h05

`define LSW_CMP_CTL_WMASK  32'h03F00FFC
`define LSW_CMP_G_TYPE     25
`define LSW_CMP_H_TYPE     22
`define LSW_CMP_G_SIGN     11
`define LSW_CMP_H_SIGN     10
`define LSW_CMP_G_MASK     9
`define LSW_CMP_H_MASK     5

`define LSW_WATCH_BASE     31
`define LSW_WATCH_STRIDE   10
`define LSW_BRK_UNMASKED   11
`define LSW_PORT_TRAP0     3
`define LSW_SOFT_TRAP0     1
`define LSW_WATCH_WMASK    32'hFFFFF803
`define LSW_WATCH_RESET    32'h00000000

`define LSW_CNT_PRESET_MSB 31
`define LSW_CNT_SRC_MSB    1
`define LSW_CNT_WMASK      32'hFFFF0003

`define LSW_CAUSE_RST      30
`define LSW_CAUSE_CHECKSTOP 29
`define LSW_CAUSE_MCHECK   28
`define LSW_CAUSE_EXT      25
`define LSW_CAUSE_ALIGN    24
`define LSW_CAUSE_PROG     23
`define LSW_CAUSE_FPU      22
`define LSW_CAUSE_DEC      21
`define LSW_CAUSE_SYSCALL  18
`define LSW_CAUSE_RESET    32'h00000000

`endif

/* File: verilog/lsw_pkg.sv */
/*
 types shared by the load/store watch block and its data comparator.
 assumes nothing of its surroundings.
*/
package lsw_pkg;
    typedef enum logic [1:0] {
        SRC_OFF  = 2'h0,
        SRC_INSN = 2'h1,
        SRC_LS   = 2'h2,
        SRC_RSVD = 2'h3
    } cnt_src_t;

    typedef enum logic [1:0] {
        PICK_FIRST  = 2'h0,
        PICK_SECOND = 2'h1,
        PICK_AND    = 2'h2,
        PICK_OR     = 2'h3
    } pick_t;

    typedef enum logic [2:0] {
        CMP_EQ = 3'h4,
        CMP_LT = 3'h5,
        CMP_GT = 3'h6,
        CMP_NE = 3'h7
    } cmp_type_t;
endpackage
